// ### ebps_bus_phases.sv
// The address map and strobed register access were left to the implementer.
module ebps_bus_phases
    import ebps_pkg::*;
(
    input  wire logic                          clk_sys,    // System clock
    input  wire logic                          sys_rst,    // Sync reset
    input  wire logic                          linkClk,    // Bus timing clock
    input  wire logic [ebps_pkg::REG_A_W-1:0]  regAddr,    // Register address
    input  wire logic [ebps_pkg::REG_D_W-1:0]  regWdata,   // Register data in
    input  wire logic                          regWr,      // Write strobe
    input  wire logic                          regRd,      // Read strobe
    output logic      [ebps_pkg::REG_D_W-1:0]  regRdata,   // Read data
    input  wire logic                          reqValid,   // Start a cycle
    input  wire logic                          reqWrite,   // Cycle is write
    input  wire logic [ebps_pkg::ADDR_W-1:0]   reqAddr,    // Cycle address
    input  wire logic [ebps_pkg::DATA_W-1:0]   reqWdata,   // Write data
    output logic                               reqReady,   // Can take cycle
    output logic                               cycDone,    // Cycle finished
    output logic      [ebps_pkg::DATA_W-1:0]   cycRdata,   // Read result
    output logic      [ebps_pkg::ADDR_W-1:0]   busAddr,    // Address pins
    output logic      [ebps_pkg::DATA_W-1:0]   busDataOut, // Data pins out
    output logic                               busDataOe,  // Data pins drive
    input  wire logic [ebps_pkg::DATA_W-1:0]   busDataIn,  // Data pins in
    output logic                               csN,        // Chip select
    output logic                               rdN,        // Read strobe
    output logic                               wrN,        // Write strobe
    output logic                               ale,        // Address latch
    input  wire logic                          readyPin,   // Ready handshake
    output logic                               clockOutputSignal, // Ref clock
    output logic                               fastDrvEn   // Fast driver on
);
    import ebps_pkg::*;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [1:0] clampSetup(input logic [1:0] v);
        if (v < AS_MIN) begin
            return AS_MIN;
        end
        if (v > AS_MAX) begin
            return AS_MAX;
        end
        return v;
    endfunction : clampSetup

    function automatic ebps_phase_e afterAddr(input logic [1:0] cmd,
                                              input logic       ws);
        if (cmd != 2'h0) begin
            return PH_CMD;
        end
        return ws ? PH_WSETUP : PH_ACCESS;
    endfunction : afterAddr

    // ****************************************************************
    // System side registers
    // ****************************************************************
    logic [REG_D_W-1:0]  cfgReg;
    logic                busy;
    logic                lastWrite;
    logic [ST_CNT_W-1:0] cycCount;
    logic [REG_D_W-1:0]  heldCfg;
    logic [ADDR_W-1:0]   heldAddr;
    logic [DATA_W-1:0]   heldWdata;
    logic                heldWrite;
    logic                reqTgl;
    logic                ackSeen;
    logic [SYNC_STAGES-1:0] ackSync;
    logic                ackEdge;
    logic                refTgl;

    // Link side state
    logic                   lRst;
    logic [SYNC_STAGES-1:0] lRstSync;
    logic [SYNC_STAGES-1:0] reqSync;
    logic                   reqSeen;
    logic [RDY_STAGES-1:0]  rdySync;
    ebps_phase_e            phase;
    logic [CNT_W-1:0]       cnt;
    logic [REG_D_W-1:0]     lCfg;
    logic [ADDR_W-1:0]      lAddr;
    logic [DATA_W-1:0]      lWdata;
    logic                   lWrite;
    logic [ADDR_W-1:WIN_LSB] lastWin;
    logic                   winValid;
    logic                   lDone;
    logic                   ackTgl;
    logic [DATA_W-1:0]      lRdata;

    logic                   reqEdge;
    logic                   rdyLevel;
    logic                   rdyActive;
    logic [1:0]             cfgCmd;
    logic                   cfgWs;
    logic [CNT_W-1:0]       cfgAcc;
    logic [1:0]             cfgHold;
    logic [2:0]             setupLen;
    logic                   winChange;

    assign ackEdge  = ackSync[SYNC_STAGES-1] ^ ackSeen;
    assign reqReady = ~busy;

    // ****************************************************************
    // Register port
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cfgReg <= CFG_RESET;
        end else if (regWr && regAddr == OFF_CFG) begin
            cfgReg <= regWdata & REG_D_W'((64'h1 << CFG_USED_W) - 1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            regRdata <= '0;
        end else if (regRd) begin
            unique case (regAddr)
                OFF_CFG: begin
                    regRdata <= cfgReg;
                end
                OFF_STATUS: begin
                    regRdata <= '0;
                    regRdata[ST_BUSY_BIT] <= busy;
                    regRdata[ST_WRITE_BIT] <= lastWrite;
                    regRdata[ST_CNT_LSB +: ST_CNT_W] <= cycCount;
                end
                OFF_RDDATA: begin
                    regRdata <= REG_D_W'(cycRdata);
                end
                default: begin
                    regRdata <= '0;
                end
            endcase
        end else begin
            regRdata <= '0;
        end
    end

    // ****************************************************************
    // Request launch and completion, system side
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            busy      <= 1'b0;
            reqTgl    <= 1'b0;
            heldCfg   <= CFG_RESET;
            heldAddr  <= '0;
            heldWdata <= '0;
            heldWrite <= 1'b0;
        end else if (reqValid && !busy) begin
            // Held words stay put until the link side acknowledges
            busy      <= 1'b1;
            reqTgl    <= ~reqTgl;
            heldCfg   <= cfgReg;
            heldAddr  <= reqAddr;
            heldWdata <= reqWdata;
            heldWrite <= reqWrite;
        end else if (ackEdge) begin
            busy <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ackSync <= '0;
            ackSeen <= 1'b0;
        end else begin
            ackSync <= {ackSync[SYNC_STAGES-2:0], ackTgl};
            ackSeen <= ackSync[SYNC_STAGES-1];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cycDone   <= 1'b0;
            cycRdata  <= '0;
            lastWrite <= 1'b0;
            cycCount  <= '0;
        end else begin
            cycDone <= ackEdge;
            if (ackEdge) begin
                lastWrite <= heldWrite;
                cycCount  <= cycCount + 1'b1;
                if (!heldWrite) begin
                    cycRdata <= lRdata; // Stable until the next read completes
                end
            end
        end
    end

    // ****************************************************************
    // Reference clock output
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            refTgl    <= 1'b0;
            fastDrvEn <= 1'b0;
        end else begin
            refTgl    <= cfgReg[CFG_REF_BIT] ? ~refTgl : 1'b0;
            fastDrvEn <= cfgReg[CFG_REF_BIT];
        end
    end

    assign clockOutputSignal = refTgl;

    // ****************************************************************
    // Crossings into the link domain
    // ****************************************************************
    ebps_sync #(.STAGES(SYNC_STAGES)) uRstSync (
        .clk (linkClk),
        .rst (1'b0),
        .d   (sys_rst),
        .q   (lRstSync)
    );

    assign lRst = lRstSync[SYNC_STAGES-1];

    ebps_sync #(.STAGES(SYNC_STAGES)) uReqSync (
        .clk (linkClk),
        .rst (lRst),
        .d   (reqTgl),
        .q   (reqSync)
    );

    ebps_sync #(.STAGES(RDY_STAGES)) uRdySync (
        .clk (linkClk),
        .rst (lRst),
        .d   (readyPin),
        .q   (rdySync)
    );

    // Async ready taps one stage later
    assign rdyLevel  = lCfg[CFG_ASYNC_BIT] ? rdySync[RDY_STAGES-1]
                                           : rdySync[SYNC_STAGES-1];
    assign rdyActive = ~(rdyLevel ^ lCfg[CFG_POL_BIT]);
    assign reqEdge   = reqSync[SYNC_STAGES-1] ^ reqSeen;

    // ****************************************************************
    // Phase lengths
    // ****************************************************************
    assign cfgCmd    = lCfg[CFG_CMD_LSB +: 2];
    assign cfgWs     = lCfg[CFG_WS_BIT];
    assign cfgAcc    = lCfg[CFG_ACC_LSB +: CNT_W];
    assign cfgHold   = lCfg[CFG_HOLD_LSB +: 2];
    assign winChange = !winValid || lastWin != lAddr[ADDR_W-1:WIN_LSB];
    assign setupLen  = {1'b0, clampSetup(lCfg[CFG_AS_LSB +: 2])}
                     + (winChange ? {1'b0, lCfg[CFG_ASX_LSB +: 2]}
                                  : 3'h0);

    // ****************************************************************
    // Phase sequencer
    // ****************************************************************
    always_ff @(posedge linkClk) begin
        if (lRst) begin
            phase    <= PH_IDLE;
            cnt      <= '0;
            reqSeen  <= 1'b0;
            lCfg     <= CFG_RESET;
            lAddr    <= '0;
            lWdata   <= '0;
            lWrite   <= 1'b0;
            lastWin  <= '0;
            winValid <= 1'b0;
            lDone    <= 1'b0;
        end else begin
            lDone <= 1'b0;
            cnt   <= cnt + 1'b1;
            unique case (phase)
                PH_IDLE: begin
                    cnt <= '0;
                    if (reqEdge) begin
                        reqSeen <= reqSync[SYNC_STAGES-1];
                        lCfg    <= heldCfg;
                        lAddr   <= heldAddr;
                        lWdata  <= heldWdata;
                        lWrite  <= heldWrite;
                        phase   <= PH_ADDR;
                    end
                end
                PH_ADDR: begin
                    if (cnt == CNT_W'(setupLen - 3'h1)) begin
                        cnt      <= '0;
                        lastWin  <= lAddr[ADDR_W-1:WIN_LSB];
                        winValid <= 1'b1;
                        phase    <= afterAddr(cfgCmd, cfgWs);
                    end
                end
                PH_CMD: begin
                    if (cnt == CNT_W'(cfgCmd - 2'h1)) begin
                        cnt   <= '0;
                        phase <= cfgWs ? PH_WSETUP : PH_ACCESS;
                    end
                end
                PH_WSETUP: begin
                    cnt   <= '0;
                    phase <= PH_ACCESS;
                end
                PH_ACCESS: begin
                    if (cnt == cfgAcc) begin
                        cnt <= '0;
                        if (lCfg[CFG_RDYEN_BIT]) begin
                            phase <= PH_READY;
                        end else if (cfgHold != 2'h0) begin
                            phase <= PH_HOLD;
                        end else begin
                            phase <= PH_IDLE;
                            lDone <= 1'b1;
                        end
                    end
                end
                PH_READY: begin
                    cnt <= '0;
                    if (rdyActive) begin
                        if (cfgHold != 2'h0) begin
                            phase <= PH_HOLD;
                        end else begin
                            phase <= PH_IDLE;
                            lDone <= 1'b1;
                        end
                    end
                end
                PH_HOLD: begin
                    if (cnt == CNT_W'(cfgHold - 2'h1)) begin
                        cnt   <= '0;
                        phase <= PH_IDLE;
                        lDone <= 1'b1;
                    end
                end
                default: begin
                    phase <= PH_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Pin drive, one timing unit behind the sequencer
    // ****************************************************************
    always_ff @(posedge linkClk) begin
        if (lRst) begin
            csN        <= 1'b1;
            rdN        <= 1'b1;
            wrN        <= 1'b1;
            ale        <= 1'b0;
            busAddr    <= '0;
            busDataOut <= '0;
            busDataOe  <= 1'b0;
        end else begin
            csN <= (phase == PH_IDLE);
            ale <= (phase == PH_ADDR);
            rdN <= !(!lWrite &&
                     (phase == PH_ACCESS || phase == PH_READY));
            wrN <= !(lWrite &&
                     (phase == PH_ACCESS || phase == PH_READY));
            if (phase != PH_IDLE) begin
                busAddr <= lAddr;
            end
            if (lCfg[CFG_MUX_BIT] && phase == PH_ADDR) begin
                busDataOut <= lAddr[DATA_W-1:0];
                busDataOe  <= 1'b1;
            end else if (lWrite && phase != PH_IDLE &&
                         phase != PH_ADDR) begin
                busDataOut <= lWdata;
                busDataOe  <= 1'b1;
            end else begin
                busDataOe  <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Read latch and acknowledge
    // ****************************************************************
    always_ff @(posedge linkClk) begin
        if (lRst) begin
            lRdata <= '0;
            ackTgl <= 1'b0;
        end else begin
            // Latched on the very edge that lifts the read strobe,
            // the partner holds data up to that edge
            if (!rdN && phase != PH_ACCESS && phase != PH_READY) begin
                lRdata <= busDataIn;
            end
            if (lDone) begin
                ackTgl <= ~ackTgl;
            end
        end
    end

endmodule : ebps_bus_phases

// ### ebps_bus_phases_properties.sv
module ebps_bus_phases_properties (
    input  wire logic clk_sys,           // System clock
    input  wire logic sys_rst,           // Sync reset
    input  wire logic linkClk,           // Timing clock
    input  wire logic reqValid,          // Start cycle
    input  wire logic reqReady,          // Can take cycle
    input  wire logic cycDone,           // Cycle finished
    input  wire logic busDataOe,         // Data drive
    input  wire logic csN,               // Chip select
    input  wire logic rdN,               // Read strobe
    input  wire logic wrN,               // Write strobe
    input  wire logic ale,               // Address latch
    input  wire logic clockOutputSignal, // Ref clock
    input  wire logic fastDrvEn          // Fast driver
);
    timeunit 1ns;
    timeprecision 1ps;

    // Link pins settle only after the link side has left reset
    logic [3:0] rstPipe = 4'hF;
    logic       linkRst;

    always @(posedge linkClk) begin
        rstPipe <= {rstPipe[2:0], sys_rst};
    end

    assign linkRst = sys_rst || (rstPipe != 4'h0);

    // ********
    // Pin phases
    // ********
    sequence strobeEnd;
        $rose(rdN) || $rose(wrN);
    endsequence

    setup_len_a: assert property (
        @(posedge linkClk) disable iff (linkRst) $rose(ale) |-> ##[1:5] !ale)
        else $error("address setup out of range");
    strobe_cs_a: assert property (
        @(posedge linkClk) disable iff (linkRst)
        !(rdN && wrN) |-> !csN && !ale && (rdN || wrN))
        else $error("strobe outside access phase");
    hold_end_a: assert property (
        @(posedge linkClk) disable iff (linkRst) strobeEnd |-> ##[0:3] csN)
        else $error("hold phase too long");
    rd_float_a: assert property (
        @(posedge linkClk) disable iff (linkRst) !rdN |-> !busDataOe)
        else $error("data pins driven in read");
    wr_drive_a: assert property (
        @(posedge linkClk) disable iff (linkRst) !wrN |-> busDataOe)
        else $error("write data not driven");
    // ********
    // Request side and clock out
    // ********
    req_busy_a: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        reqValid && reqReady |=> !reqReady [*2])
        else $error("busy not shown after request");
    done_pulse_a: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        cycDone |-> reqReady ##1 !cycDone)
        else $error("done not a single pulse");
    ref_run_a: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        fastDrvEn && $past(fastDrvEn) |-> $changed(clockOutputSignal))
        else $error("reference clock stalled");
    ref_off_a: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        !fastDrvEn |-> !clockOutputSignal)
        else $error("reference clock without driver");
endmodule : ebps_bus_phases_properties

bind ebps_bus_phases ebps_bus_phases_properties ebps_bus_phases_properties_i (
    .clk_sys, .sys_rst, .linkClk, .reqValid, .reqReady, .cycDone, .busDataOe,
    .csN, .rdN, .wrN, .ale, .clockOutputSignal, .fastDrvEn);

// ### ebps_ext_mem.sv
module ebps_ext_mem (
    input  wire logic                        linkClk,    // Timing clock
    input  wire logic                        csN,        // Chip select
    input  wire logic                        rdN,        // Read strobe
    input  wire logic                        wrN,        // Write strobe
    input  wire logic [ebps_pkg::ADDR_W-1:0] busAddr,    // Address pins
    input  wire logic [ebps_pkg::DATA_W-1:0] busDataOut, // From device
    output logic      [ebps_pkg::DATA_W-1:0] busDataIn,  // To device
    output logic                             readyPin,   // Ready out
    input  wire logic [3:0]                  waitN,      // Units to ready
    input  wire logic                        rdyHigh     // Ready polarity
);
    timeunit 1ns;
    timeprecision 1ps;
    import ebps_pkg::*;
    logic [DATA_W-1:0] mem [256];
    logic [DATA_W-1:0] junk = 16'hA5C3;
    int                held = 0;

    always @(posedge linkClk) begin
        junk <= ~junk ^ 16'h0101;
        if (!csN && !wrN) mem[busAddr[7:0]] <= busDataOut;
        held <= (rdN && wrN) ? 0 : held + 1;
    end
    // Garbage once the strobe is released
    assign busDataIn = (!csN && !rdN) ? mem[busAddr[7:0]] : junk;
    assign readyPin = (held >= waitN) == rdyHigh;
endmodule : ebps_ext_mem

// ### ebps_pkg.sv
package ebps_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int ADDR_W     = 24;
    localparam int DATA_W     = 16;
    localparam int REG_A_W    = 8;
    localparam int REG_D_W    = 32;
    localparam int CNT_W      = 5;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [REG_A_W-1:0] OFF_CFG    = 8'h00;
    localparam logic [REG_A_W-1:0] OFF_STATUS = 8'h04;
    localparam logic [REG_A_W-1:0] OFF_RDDATA = 8'h08;

    // ****************************************************************
    // Field layout of chip_select_timing_config
    // ****************************************************************
    localparam int CFG_AS_LSB    = 0;   // address_setup_length, 1..2
    localparam int CFG_ASX_LSB   = 2;   // extension on window change, 0..3
    localparam int CFG_CMD_LSB   = 4;   // command_delay_length, 0..3
    localparam int CFG_WS_BIT    = 6;   // write_setup_tristate_length, 0..1
    localparam int CFG_ACC_LSB   = 8;   // access_length minus one, 0..31
    localparam int CFG_HOLD_LSB  = 13;  // hold_length, 0..3
    localparam int CFG_RDYEN_BIT = 16;  // access governed by ready
    localparam int CFG_ASYNC_BIT = 17;  // ready taken asynchronously
    localparam int CFG_POL_BIT   = 18;  // ready active high when set
    localparam int CFG_MUX_BIT   = 19;  // multiplexed address/data bus
    localparam int CFG_REF_BIT   = 20;  // system clock divided by two on clock output
    localparam int CFG_USED_W    = 21;
    localparam logic [REG_D_W-1:0] CFG_RESET = 32'h0004_0001;

    // ****************************************************************
    // Status layout
    // ****************************************************************
    localparam int ST_BUSY_BIT  = 0;
    localparam int ST_WRITE_BIT = 1;
    localparam int ST_CNT_LSB   = 8;
    localparam int ST_CNT_W     = 16;

    // ****************************************************************
    // Timing units and crossings
    // ****************************************************************
    localparam logic [1:0] AS_MIN      = 2'h1;
    localparam logic [1:0] AS_MAX      = 2'h2;
    localparam int         WIN_LSB     = 16;
    localparam int         SYNC_STAGES = 2;
    localparam int         RDY_STAGES  = SYNC_STAGES + 1;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_ADDR,
        PH_CMD,
        PH_WSETUP,
        PH_ACCESS,
        PH_READY,
        PH_HOLD
    } ebps_phase_e;

endpackage : ebps_pkg

// ### ebps_sync.sv
module ebps_sync #(
    parameter int STAGES = 2
) (
    input  wire logic              clk,   // Destination clock
    input  wire logic              rst,   // Sync reset, active high
    input  wire logic              d,     // Foreign level
    output logic [STAGES-1:0]      q      // All stages, q[0] first
);

    if (STAGES < 2) begin : gBadStages
        $error("ebps_sync needs at least two stages");
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= {q[STAGES-2:0], d};
        end
    end

endmodule : ebps_sync

// ### tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ebps_pkg::*;

    logic               clk_sys = 1'b0;
    logic               linkClk = 1'b0;
    logic               sys_rst = 1'b1;
    logic [REG_A_W-1:0] regAddr;
    logic [REG_D_W-1:0] regWdata, regRdata, cfg, rd;
    logic               regWr, regRd, reqValid, reqWrite, reqReady, cycDone;
    logic [ADDR_W-1:0]  reqAddr, busAddr, a;
    logic [DATA_W-1:0]  reqWdata, cycRdata, busDataOut, busDataIn, d;
    logic               busDataOe, csN, rdN, wrN, ale, readyPin, rdyHigh;
    logic               clockOutputSignal, fastDrvEn, first;
    logic [3:0]         waitN;
    logic [7:0]         lastWin;
    int                 errTotal, nCompared, cnt, nAle, nMid, nAcc, nHold;

    initial forever #10 clk_sys = ~clk_sys;
    initial begin
        #7;
        forever #40 linkClk = ~linkClk;
    end

    ebps_bus_phases ebps_bus_phases_i (.clk_sys, .sys_rst, .linkClk, .regAddr,
        .regWdata, .regWr, .regRd, .regRdata, .reqValid, .reqWrite, .reqAddr,
        .reqWdata, .reqReady, .cycDone, .cycRdata, .busAddr, .busDataOut,
        .busDataOe, .busDataIn, .csN, .rdN, .wrN, .ale, .readyPin,
        .clockOutputSignal, .fastDrvEn);
    ebps_ext_mem ebps_ext_mem_i (.linkClk, .csN, .rdN, .wrN, .busAddr,
        .busDataOut, .busDataIn, .readyPin, .waitN, .rdyHigh);

    // ********
    // Phase lengths seen on the pins
    // ********
    always @(posedge linkClk) begin
        if (ale === 1'b1) nAle++;
        else if (!(rdN && wrN)) nAcc++;
        else if (csN === 1'b0 && nAcc == 0) nMid++;
        else if (csN === 1'b0) nHold++;
    end

    function automatic int setupLen(logic [31:0] c, logic chg);
        return (c[1:0] == 2'h0 ? 1 : c[1:0] == 2'h3 ? 2 : int'(c[1:0]))
            + (chg ? int'(c[3:2]) : 0);
    endfunction : setupLen

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            errTotal++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic chkRange(input int got, input int lo, input int hi);
        nCompared++;
        if (got < lo || got > hi) begin
            errTotal++;
            $display("wrong value at %0t: count %0d", $time, got);
        end
    endtask : chkRange

    task automatic wrapUp;
        $display("mismatches %0d, compares %0d", errTotal, nCompared);
        if (errTotal == 0 && nCompared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrapUp

    task automatic regW(input logic [7:0] ad, input logic [31:0] wd);
        @(posedge clk_sys);
        regAddr <= ad;
        regWdata <= wd;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask : regW

    task automatic regR(input logic [7:0] ad, output logic [31:0] q);
        @(posedge clk_sys);
        regAddr <= ad;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 q = regRdata;
    endtask : regR

    task automatic busCyc(input logic w, input logic [15:0] wd);
        int k;
        int acc;
        k = 0;
        acc = int'(cfg[12:8]) + 1;
        @(posedge clk_sys);
        nAle = 0;
        nMid = 0;
        nAcc = 0;
        nHold = 0;
        reqWrite <= w;
        reqAddr <= a;
        reqWdata <= wd;
        reqValid <= 1'b1;
        repeat (2) @(posedge clk_sys); // Second cycle lands while busy
        reqValid <= 1'b0;
        do begin
            @(posedge clk_sys);
            #1 k++;
        end while (cycDone !== 1'b1 && k < 2000);
        if (k >= 2000) begin
            errTotal++;
            wrapUp();
        end
        chk(nAle, setupLen(cfg, first || a[23:16] !== lastWin));
        chk(nMid, cfg[5:4] + cfg[6]);
        chk(nHold, cfg[14:13]);
        if (cfg[16]) chkRange(nAcc, acc + 1, acc + waitN + 6);
        else chk(nAcc, acc);
        first = 1'b0;
        lastWin = a[23:16];
    endtask : busCyc

    initial begin
        {regAddr, regWdata, regWr, regRd, reqValid, reqWrite} = '0;
        {reqAddr, reqWdata, waitN, lastWin, cnt} = '0;
        {errTotal, nCompared, nAle, nMid, nAcc, nHold} = '0;
        rdyHigh = 1'b1;
        first = 1'b1;
        void'($urandom(61726));
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (12) @(posedge clk_sys);
        regR(OFF_CFG, rd);
        chk(rd, CFG_RESET);
        regR(8'h0C, rd);
        chk(rd, 32'h0000_0000);
        for (int i = 0; i < 14; i++) begin
            cfg = i == 0 ? CFG_RESET : i == 1 ? 32'h0000_7F7F
                : $urandom & 32'h001F_7F7F;
            waitN <= 4'($urandom_range(0, 6));
            rdyHigh <= cfg[18];
            regW(OFF_CFG, cfg | 32'hFFE0_0000);
            regR(OFF_CFG, rd);
            chk(rd, cfg);
            a = {7'h00, 1'($urandom), 8'h00, 8'($urandom)};
            d = 16'($urandom);
            busCyc(1'b1, d);
            busCyc(1'b0, 16'h0000);
            chk(cycRdata, d);
            cnt += 2;
            regR(OFF_STATUS, rd);
            chk(rd, cnt << 8);
            regR(OFF_RDDATA, rd);
            chk(rd, {16'h0000, d});
            chk(fastDrvEn, cfg[20]);
            @(posedge clk_sys);
            #1 rd[0] = clockOutputSignal;
            @(posedge clk_sys);
            #1 chk(clockOutputSignal, cfg[20] & ~rd[0]);
            chk(reqReady, 1'b1);
        end
        wrapUp();
    end
endmodule : tb_top
